// File: design/sac_top.sv
// Sequence control for a 12-bit successive-approximation converter with AXI4-Lite registers
`include "sac_defs.svh"

module sac_top
    import sac_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int NBUF   = 16
) (
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              rc_tick,
    input  wire logic [5:0]        ext_trigger,
    input  wire logic              comparator_high,
    input  wire logic [15:0]       pin_in,
    output sac_mux_t               mux_out,
    output logic                   sample_connect,
    output logic [11:0]            sar_trial,
    output logic                   analog_power_en,
    output logic [15:0]            digital_buffer_en,
    output logic                   conversion_done,
    output logic                   sequence_done
);
    // ******************************************************************
    // Register state
    // ******************************************************************
    logic [15:0] ctrl1, ctrl2, ctrl3, chsel, pin_config, scan_sel;
    logic        sample_bit, done_flag;
    logic [15:0] port_value;
    logic [11:0] last_result;
    logic [11:0] res_buf [NBUF];
    sac_state_t  state, next_state;
    logic [6:0]  div_acc;
    logic [4:0]  sample_bit_cnt;
    logic [3:0]  conv_cnt, buf_idx, scan_pos;
    logic [11:0] sar_mask;
    logic        phase_b;

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s, input logic [15:0] m);
        logic [15:0] v;
        v = old;
        if (s[0]) v[7:0] = d[7:0];
        if (s[1]) v[15:8] = d[15:8];
        return v & m;
    endfunction

    function automatic logic [3:0] first_sel(input logic [15:0] m);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 15; i >= 0; i--) if (m[i]) r = 4'(i);
        return r;
    endfunction

    function automatic logic [3:0] next_sel(input logic [15:0] m, input logic [3:0] p);
        logic [3:0] r;
        logic       hit;
        r = first_sel(m);
        hit = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (!hit && m[i] && 4'(i) > p) begin
                r = 4'(i);
                hit = 1'b1;
            end
        end
        return r;
    endfunction

    // ******************************************************************
    // Bus slave decode
    // ******************************************************************
    logic              aw_hold, w_hold;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    wire wr_fire  = aw_hold && w_hold && !s_axi_bvalid;
    wire rd_fire  = s_axi_arvalid && s_axi_arready;
    wire wr_c1    = wr_fire && aw_addr == `SAC_OFF_CTRL1;
    wire wr_c2    = wr_fire && aw_addr == `SAC_OFF_CTRL2;
    wire wr_c3    = wr_fire && aw_addr == `SAC_OFF_CTRL3;
    wire wr_ch    = wr_fire && aw_addr == `SAC_OFF_CHSEL;
    wire wr_pin   = wr_fire && aw_addr == `SAC_OFF_PINCFG;
    wire wr_scan  = wr_fire && aw_addr == `SAC_OFF_SCANSEL;
    wire wr_known = wr_c1 || wr_c2 || wr_c3 || wr_ch || wr_pin || wr_scan;
    wire sw_bit0  = wr_c1 && w_strb[0];

    assign s_axi_awready = ce && !aw_hold && !s_axi_bvalid;
    assign s_axi_wready  = ce && !w_hold && !s_axi_bvalid;
    assign s_axi_arready = ce && !s_axi_rvalid;

    // ******************************************************************
    // Control fields
    // ******************************************************************
    wire        module_on = ctrl1[`SAC_C1_ON];
    wire [2:0]  trigger_source_select      = ctrl1[`SAC_C1_TRIGGER_SOURCE_SELECT_HI:`SAC_C1_TRIGGER_SOURCE_SELECT_LO];
    wire        auto_sample      = ctrl1[`SAC_C1_AUTO_SAMPLE];
    wire        scan_en   = ctrl2[`SAC_C2_SCAN];
    wire [3:0]  smpi      = ctrl2[`SAC_C2_SMPI_HI:`SAC_C2_SMPI_LO];
    wire        alternate_input_sets      = ctrl2[`SAC_C2_ALTERNATE_INPUT_SETS];
    wire [4:0]  auto_sample_clock_count      = ctrl3[`SAC_C3_AUTO_SAMPLE_CLOCK_COUNT_HI:`SAC_C3_AUTO_SAMPLE_CLOCK_COUNT_LO];
    wire        rc_sel    = ctrl3[`SAC_C3_RC];
    wire [5:0]  bit_clock_divider      = ctrl3[`SAC_C3_BIT_CLOCK_DIVIDER_HI:`SAC_C3_BIT_CLOCK_DIVIDER_LO];
    wire [3:0]  a_pos     = chsel[`SAC_CH_APOS_HI:`SAC_CH_APOS_LO];
    wire        a_neg     = chsel[`SAC_CH_ANEG];
    wire [3:0]  b_pos     = chsel[`SAC_CH_BPOS_HI:`SAC_CH_BPOS_LO];
    wire        b_neg     = chsel[`SAC_CH_BNEG];
    wire        tad_short = (7'(bit_clock_divider) + 7'h01) < 7'(2 * `SAC_TAD_MIN_CYC);

    // ******************************************************************
    // Bit clock enable
    // ******************************************************************
    // Half-cycle accumulator: adds 2 per clock, wraps at divider+1, so
    // odd settings give a uniform period and even ones an exact average.
    wire [6:0] div_mod  = 7'(bit_clock_divider) + 7'h01;
    wire [6:0] div_sum  = div_acc + 7'h02;
    wire       div_tick = div_sum >= div_mod;
    wire       bit_tick = rc_sel ? rc_tick : div_tick;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_acc <= 7'h00;
        end else if (ce) begin
            if (!module_on || rc_sel) div_acc <= 7'h00;
            else if (div_tick) div_acc <= div_sum - div_mod;
            else div_acc <= div_sum;
        end
    end

    // ******************************************************************
    // Sequencer
    // ******************************************************************
    wire sampling   = state == SAC_SAMPLE;
    wire converting = state == SAC_CONVERT;
    wire conv_end   = converting && bit_tick && conv_cnt == `SAC_CONV_LAST;
    wire seq_last   = buf_idx == smpi;
    wire ext_pick   = trigger_source_select != 3'h0 && trigger_source_select != 3'h7 && ext_trigger[3'(trigger_source_select - 3'h1)];
    wire trig_sw    = trigger_source_select == 3'h0 && !sample_bit;
    wire trig_clk   = trigger_source_select == 3'h7 && sample_bit_cnt >= auto_sample_clock_count;
    wire trigger    = sampling && (trig_sw || trig_clk || ext_pick);
    wire hw_set     = module_on && auto_sample && ((state == SAC_IDLE) || conv_end);
    wire hw_clr     = !module_on || (trigger && trigger_source_select != 3'h0);
    wire next_sample_bit  = hw_set ? 1'b1 : hw_clr ? 1'b0 : sw_bit0 ? w_data[`SAC_C1_SAMPLE_BIT] : sample_bit;
    wire next_done  = conv_end ? 1'b1 : sw_bit0 ? w_data[`SAC_C1_DONE] : done_flag;

    always_comb begin
        next_state = state;
        unique case (state)
            SAC_IDLE:    if (module_on && next_sample_bit) next_state = SAC_SAMPLE;
            SAC_SAMPLE:  if (!module_on) next_state = SAC_IDLE;
                         else if (trigger) next_state = SAC_CONVERT;
            SAC_CONVERT: if (!module_on) next_state = SAC_IDLE;
                         else if (conv_end) next_state = auto_sample ? SAC_SAMPLE : SAC_IDLE;
        endcase
    end

    // Set A with optional scan, or set B on alternate conversions
    wire [3:0] next_pos    = phase_b ? b_pos : scan_en ? scan_pos : a_pos;
    wire       next_neg    = phase_b ? b_neg : a_neg;
    wire       next_ground = pin_config[next_pos];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= SAC_IDLE;
            sample_bit <= 1'b0;
            done_flag <= 1'b0;
            sample_bit_cnt <= 5'h00;
            conv_cnt <= 4'h0;
        end else if (ce) begin
            state <= next_state;
            sample_bit <= next_sample_bit;
            done_flag <= next_done;
            if (!sampling) sample_bit_cnt <= 5'h00;
            else if (bit_tick && sample_bit_cnt != 5'h1F) sample_bit_cnt <= sample_bit_cnt + 5'h01;
            if (!converting) conv_cnt <= 4'h0;
            else if (bit_tick) conv_cnt <= conv_cnt + 4'h1;
        end
    end

    // ******************************************************************
    // Successive approximation
    // ******************************************************************
    wire [11:0] sar_keep = comparator_high ? sar_trial : sar_trial & ~sar_mask;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sar_trial <= 12'h000;
            sar_mask <= 12'h000;
        end else if (ce) begin
            if (trigger) begin
                sar_trial <= `SAC_SAR_TOP;
                sar_mask <= `SAC_SAR_TOP;
            end else if (converting && bit_tick && conv_cnt < `SAC_SAR_BITS) begin
                sar_trial <= sar_keep | (sar_mask >> 1);
                sar_mask <= sar_mask >> 1;
            end
        end
    end

    // ******************************************************************
    // Input selection, scanning and result storage
    // ******************************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            buf_idx <= 4'h0;
            phase_b <= 1'b0;
            scan_pos <= 4'h0;
            last_result <= 12'h000;
            conversion_done <= 1'b0;
            sequence_done <= 1'b0;
        end else if (ce) begin
            conversion_done <= conv_end;
            sequence_done <= conv_end && seq_last;
            if (!module_on) begin
                buf_idx <= 4'h0;
                phase_b <= 1'b0;
                scan_pos <= first_sel(scan_sel);
            end else if (conv_end) begin
                last_result <= sar_trial;
                buf_idx <= seq_last ? 4'h0 : buf_idx + 4'h1;
                phase_b <= alternate_input_sets && !seq_last && !phase_b;
                // scan advances on set A only
                if (seq_last) scan_pos <= first_sel(scan_sel);
                else if (scan_en && !phase_b) scan_pos <= next_sel(scan_sel, scan_pos);
            end
        end
    end

    // Buffer words hold no reset; software reads them only after done
    always_ff @(posedge clk) begin
        if (ce && module_on && conv_end) res_buf[buf_idx] <= sar_trial;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mux_out <= '0;
            sample_connect <= 1'b0;
            analog_power_en <= 1'b0;
            port_value <= `SAC_RST16;
        end else if (ce) begin
            mux_out <= '{pos: next_pos, neg: next_neg, ground: next_ground};
            sample_connect <= next_state == SAC_SAMPLE;
            analog_power_en <= module_on;
            port_value <= pin_in & pin_config;
        end
    end
    // input buffer only for digital pins
    assign digital_buffer_en = pin_config;

    // ******************************************************************
    // Register writes and bus responses
    // ******************************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl1 <= `SAC_RST16;
            ctrl2 <= `SAC_RST16;
            ctrl3 <= `SAC_RST16;
            chsel <= `SAC_RST16;
            pin_config <= `SAC_RST16;
            scan_sel <= `SAC_RST16;
        end else if (ce) begin
            if (wr_c1) ctrl1 <= merge(ctrl1, w_data, w_strb, `SAC_C1_MASK);
            if (wr_c2) ctrl2 <= merge(ctrl2, w_data, w_strb, `SAC_C2_MASK);
            if (wr_c3) ctrl3 <= merge(ctrl3, w_data, w_strb, `SAC_C3_MASK);
            if (wr_ch) chsel <= merge(chsel, w_data, w_strb, `SAC_CH_MASK);
            if (wr_pin) pin_config <= merge(pin_config, w_data, w_strb, 16'hFFFF);
            if (wr_scan) scan_sel <= merge(scan_sel, w_data, w_strb, 16'hFFFF);
        end
    end

    wire [ADDR_W-1:0] ra     = s_axi_araddr;
    wire              rd_buf = ra[`SAC_BUF_SEL_HI:`SAC_BUF_SEL_LO] == `SAC_BUF_SEL_VAL
                               && ra[1:0] == 2'h0;
    wire [15:0] c1_rd  = ctrl1 | {14'h0000, sample_bit, done_flag};
    wire [15:0] st_rd  = {8'h00, buf_idx, 1'b0, tad_short, converting, sampling};
    logic [31:0] rd_word;
    logic        rd_ok;

    always_comb begin
        rd_ok = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (ra)
            `SAC_OFF_CTRL1:   rd_word = {16'h0000, c1_rd};
            `SAC_OFF_CTRL2:   rd_word = {16'h0000, ctrl2};
            `SAC_OFF_CTRL3:   rd_word = {16'h0000, ctrl3};
            `SAC_OFF_CHSEL:   rd_word = {16'h0000, chsel};
            `SAC_OFF_PINCFG:  rd_word = {16'h0000, pin_config};
            `SAC_OFF_SCANSEL: rd_word = {16'h0000, scan_sel};
            `SAC_OFF_LAST:    rd_word = {20'h0_0000, last_result};
            `SAC_OFF_PORT:    rd_word = {16'h0000, port_value};
            `SAC_OFF_STATUS:  rd_word = {16'h0000, st_rd};
            default: begin
                rd_ok = rd_buf;
                if (rd_buf) rd_word = {20'h0_0000, res_buf[ra[5:2]]};
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SAC_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `SAC_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ******************************************************************
    // Checks
    // ******************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n || !ce);

    logic [3:0] chk_ticks;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) chk_ticks <= 4'h0;
        else if (ce) chk_ticks <= !converting ? 4'h0 : chk_ticks + 4'(bit_tick);
    end

    property p_conv_len;
        conv_end |-> chk_ticks == 4'd13 ##1 conversion_done;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion not 14 ticks");

    // Clocks since the last bit tick; odd divider settings give an even spacing
    logic [5:0] chk_gap;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) chk_gap <= 6'h00;
        else if (ce) chk_gap <= (bit_tick || !module_on || rc_sel) ? 6'h00 : chk_gap + 6'h01;
    end

    property p_div_gap;
        (module_on && !rc_sel && bit_clock_divider[0] && bit_tick) |-> chk_gap == {1'b0, bit_clock_divider[5:1]};
    endproperty
    a_div_gap: assert property (p_div_gap) else $error("bit clock period wrong");

    property p_rc;
        rc_sel && converting |=> conv_cnt == $past(conv_cnt) + 4'($past(rc_tick));
    endproperty
    a_rc: assert property (p_rc) else $error("rc source not used");

    property p_port_zero;
        ##1 (port_value & ~$past(pin_config)) == 16'h0000;
    endproperty
    a_port_zero: assert property (p_port_zero) else $error("analog pin read nonzero");

    property p_ground;
        pin_config[next_pos] |=> mux_out.ground && mux_out.pos == $past(next_pos);
    endproperty
    a_ground: assert property (p_ground) else $error("digital pin not grounded");

    property p_no_alt;
        !alternate_input_sets && !phase_b |=> !phase_b;
    endproperty
    a_no_alt: assert property (p_no_alt) else $error("set B used without alternate");

    property p_scan_neg;
        scan_en && !phase_b |=> mux_out.neg == $past(a_neg) && mux_out.pos == $past(scan_pos);
    endproperty
    a_scan_neg: assert property (p_scan_neg) else $error("scan select wrong");

    property p_off;
        !module_on |=> state == SAC_IDLE && !analog_power_en && !sample_connect;
    endproperty
    a_off: assert property (p_off) else $error("module off but active");

    sequence s_sw_clear;
        sampling && trigger_source_select == 3'h0 && module_on && !sample_bit;
    endsequence
    property p_manual_trig;
        s_sw_clear |=> converting ##1 sar_trial == `SAC_SAR_TOP || conv_cnt != 4'h0;
    endproperty
    a_manual_trig: assert property (p_manual_trig) else $error("manual trigger lost");

    property p_auto;
        conv_end && auto_sample && module_on |=> sample_bit && sampling;
    endproperty
    a_auto: assert property (p_auto) else $error("auto sample not resumed");
endmodule

// File: include/sac_defs.svh
// Register map, field positions, reset values and timing counts of the converter control
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH

`define SAC_OFF_CTRL1     8'h00
`define SAC_OFF_CTRL2     8'h04
`define SAC_OFF_CTRL3     8'h08
`define SAC_OFF_CHSEL     8'h0C
`define SAC_OFF_PINCFG    8'h10
`define SAC_OFF_SCANSEL   8'h14
`define SAC_OFF_LAST      8'h18
`define SAC_OFF_PORT      8'h1C
`define SAC_OFF_STATUS    8'h20
`define SAC_OFF_BUF       8'h40
`define SAC_BUF_SEL_HI    7
`define SAC_BUF_SEL_LO    6
`define SAC_BUF_SEL_VAL   2'h1

// Control register one
`define SAC_C1_ON         15
`define SAC_C1_TRIGGER_SOURCE_SELECT_HI    7
`define SAC_C1_TRIGGER_SOURCE_SELECT_LO    5
`define SAC_C1_AUTO_SAMPLE       2
`define SAC_C1_SAMPLE_BIT       1
`define SAC_C1_DONE       0
`define SAC_C1_MASK       16'h80E4
// Control register two
`define SAC_C2_SCAN       10
`define SAC_C2_SMPI_HI    5
`define SAC_C2_SMPI_LO    2
`define SAC_C2_ALTERNATE_INPUT_SETS       0
`define SAC_C2_MASK       16'h043D
// Control register three
`define SAC_C3_AUTO_SAMPLE_CLOCK_COUNT_HI    12
`define SAC_C3_AUTO_SAMPLE_CLOCK_COUNT_LO    8
`define SAC_C3_RC         7
`define SAC_C3_BIT_CLOCK_DIVIDER_HI    5
`define SAC_C3_BIT_CLOCK_DIVIDER_LO    0
`define SAC_C3_MASK       16'h1FBF
// Channel select register
`define SAC_CH_APOS_HI    3
`define SAC_CH_APOS_LO    0
`define SAC_CH_ANEG       4
`define SAC_CH_BPOS_HI    11
`define SAC_CH_BPOS_LO    8
`define SAC_CH_BNEG       12
`define SAC_CH_MASK       16'h1F1F

`define SAC_RST16         16'h0000
`define SAC_SAR_TOP       12'h800
`define SAC_SAR_BITS      4'hC
`define SAC_CONV_LAST     4'hD
`define SAC_RESP_OKAY     2'h0
`define SAC_RESP_SLVERR   2'h2

// Bit clock limit, as a time and as a count of instruction clocks
`define SAC_CLK_PS        20000
`define SAC_TAD_MIN_PS    333330
`define SAC_TAD_MIN_CYC   ((`SAC_TAD_MIN_PS + `SAC_CLK_PS - 1) / `SAC_CLK_PS)

`endif

// File: include/sac_pkg.sv
// Types shared by the converter control design
package sac_pkg;
    typedef enum logic [1:0] {
        SAC_IDLE,
        SAC_SAMPLE,
        SAC_CONVERT
    } sac_state_t;

    typedef struct packed {
        logic [3:0] pos;
        logic       neg;
        logic       ground;
    } sac_mux_t;
endpackage

// File: bench/sac_front_model.sv
// Behavioural analog front end: comparator against a held level, plus RC tick source
module sac_front_model
    import sac_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [11:0] level,
    input  sac_mux_t        mux_out,
    input  wire logic [11:0] sar_trial,
    output logic            comparator_high,
    output logic            rc_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] rc_cnt;
    // ************************************************
    // grounded input and RC tick source
    // ************************************************
    // Input n holds the level with n in its low nibble, so results name their input
    assign comparator_high = (mux_out.ground ? 12'h000 : {level[11:4], mux_out.pos}) >= sar_trial;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) rc_cnt <= 2'h0;
        else rc_cnt <= (rc_cnt == 2'h2) ? 2'h0 : rc_cnt + 2'h1;
    end
    assign rc_tick = (rc_cnt == 2'h2);
endmodule

// File: bench/testbench.sv
// Register-level tests of the converter sequence control
module testbench
    import sac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, arst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
    logic arready, rvalid, cmp, rc, apw, cdone, sdone, sconn;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [15:0] pin_in, dben;
    logic [5:0] ext;
    logic [11:0] trial;
    sac_mux_t mux;
    int mismatches, check_count, cyc, n, pulses;
    sac_top u_sac_top (.clk(clk), .arst_n(arst_n), .ce(1'b1), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rc_tick(rc), .ext_trigger(ext), .comparator_high(cmp),
        .pin_in(pin_in), .mux_out(mux), .sample_connect(sconn), .sar_trial(trial),
        .analog_power_en(apw), .digital_buffer_en(dben), .conversion_done(cdone),
        .sequence_done(sdone));
    sac_front_model u_sac_front_model (.clk(clk), .arst_n(arst_n), .level(12'hA5C),
        .mux_out(mux), .sar_trial(trial), .comparator_high(cmp), .rc_tick(rc));
    always #10 clk = ~clk;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic da, dw, t;
        da = 0;
        dw = 0;
        @(posedge clk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(negedge clk);
            t = awready & awvalid; da |= t;
            dw |= wready & wvalid;
            @(posedge clk);
            if (da) awvalid <= 0;
            if (dw) wvalid <= 0;
        end while (!(da && dw));
        do begin @(negedge clk); t = bvalid; @(posedge clk); end while (!t);
        bready <= 0;
        chk(bresp, 0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic t;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin @(negedge clk); t = arready; @(posedge clk); end while (!t);
        arvalid <= 0;
        do begin @(negedge clk); t = rvalid; d = rdata; r = rresp; @(posedge clk); end while (!t);
        rready <= 0;
        chk(d, e);
        chk(r, er);
    endtask
    task automatic convert(input int lo, input int hi);
        wr(8'h00, 32'h0000_8000);
        n = 0;
        do begin @(negedge clk); n++; end while (cdone !== 1'b1 && n < 600);
        chk(n >= lo && n <= hi, 1);
        chk(sconn, 0);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard: real run is well under two thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc >= 20000) begin mismatches++; give_verdict(); end
    end
    initial begin
        clk = 0; arst_n = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        awaddr = 0; araddr = 0; wdata = 0; pin_in = 16'hFFFF; cyc = 0; ext = 0;
        repeat (12) @(posedge clk);
        arst_n <= 1;
        rd(8'h10, 32'h0000_0000, 2'h0);
        rd(8'h1C, 32'h0000_0000, 2'h0);
        rd(8'h3C, 32'h0000_0000, 2'h2);
        chk(dben, 0);
        chk(apw, 0);
        wr(8'h10, 32'h0000_0004);
        wr(8'h0C, 32'h0000_0002);
        wr(8'h08, 32'h0000_003F);
        wr(8'h00, 32'h0000_8000);
        @(negedge clk) chk(apw, 1);
        rd(8'h1C, 32'h0000_0004, 2'h0);
        wr(8'h00, 32'h0000_8002);
        @(negedge clk) chk({26'h0, mux}, 32'h0000_0009);
        chk(sconn, 1);
        // Free-running divider: first bit period after the trigger may be partial
        convert(418, 449);
        rd(8'h18, 32'h0000_0000, 2'h0);
        wr(8'h00, 32'h0000_0000);
        wr(8'h0C, 32'h0000_0015);
        wr(8'h08, 32'h0000_00BF);
        wr(8'h00, 32'h0000_8000);
        wr(8'h00, 32'h0000_8002);
        @(negedge clk) chk({26'h0, mux}, 32'h0000_0016);
        convert(40, 50);
        rd(8'h18, 32'h0000_0A55, 2'h0);
        rd(8'h40, 32'h0000_0A55, 2'h0);
        // Auto sample, clocked trigger, scan of inputs 1, 3 alternating with input 9
        wr(8'h00, 32'h0000_0000);
        wr(8'h14, 32'h0000_004A);
        wr(8'h04, 32'h0000_040D);
        wr(8'h0C, 32'h0000_0910);
        wr(8'h08, 32'h0000_02BF);
        wr(8'h00, 32'h0000_00E4);
        wr(8'h00, 32'h0000_80E4);
        n = 0;
        pulses = 0;
        do begin
            @(negedge clk);
            if (n == 1) pulses += cdone;
            n += sdone;
        end while (n < 2);
        chk(pulses, 4);
        rd(8'h40, 32'h0000_0A51, 2'h0);
        rd(8'h44, 32'h0000_0A59, 2'h0);
        rd(8'h48, 32'h0000_0A53, 2'h0);
        rd(8'h4C, 32'h0000_0A59, 2'h0);
        // External trigger source two, manual sample start
        wr(8'h00, 32'h0000_0000);
        wr(8'h00, 32'h0000_0040);
        wr(8'h00, 32'h0000_8040);
        wr(8'h00, 32'h0000_8042);
        repeat (20) @(negedge clk);
        chk(sconn, 1);
        @(posedge clk) ext <= 6'h02;
        @(posedge clk) ext <= 6'h00;
        n = 0;
        do begin @(negedge clk); n++; end while (cdone !== 1'b1 && n < 600);
        chk(n >= 41 && n <= 43, 1);
        rd(8'h18, 32'h0000_0A51, 2'h0);
        give_verdict();
    end
endmodule
